// File: dac_channel.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module dac_channel
  import dac_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic channelPin,
  input wire logic [3:0][15:0] counterBuses,
  input wire logic debugHalt,
  output logic channelOut,
  output logic irq
);
  import dac_pkg::*;

  dac_state_t s_q;
  dac_state_t s_d;

  logic [15:0] busSel;
  logic pinRise;
  logic pinFall;
  logic selEdge;
  logic otherEdge;
  logic active;
  logic [15:0] cmpMask;
  logic eqA;
  logic eqB;
  logic matchA;
  logic matchB;
  logic outMode;
  logic accept;

  assign busSel = counterBuses[s_q.counter_bus_select];
  // The edge detector reads only the second synchroniser stage.
  assign pinRise = s_q.pinSync2 & ~s_q.pinPrev;
  assign pinFall = ~s_q.pinSync2 & s_q.pinPrev;
  assign selEdge = s_q.edgeFall ? pinFall : pinRise;
  assign otherEdge = s_q.edgeFall ? pinRise : pinFall;
  assign active = ~(s_q.freeze & debugHalt);
  assign cmpMask = 16'hffff << dac_ignore_bits(s_q.mode);
  assign eqA = ((busSel ^ s_q.dataA) & cmpMask) == 16'h0000;
  assign eqB = ((busSel ^ s_q.dataB) & cmpMask) == 16'h0000;
  // Matches fire once on arrival, so a stopped counter does not keep flagging.
  assign matchA = eqA & ~s_q.eqAPrev;
  assign matchB = eqB & ~s_q.eqBPrev;
  assign outMode = s_q.mode[3] | (s_q.mode == MODE_CMP_SECOND) | (s_q.mode == MODE_CMP_BOTH);
  assign accept = hsel & htrans[1] & hready;

  always_comb begin
    logic [1:0] setBits;
    logic [1:0] clrBits;
    logic [15:0] csrRead;
    logic [31:0] readWord;
    setBits = 2'h0;
    clrBits = 2'h0;
    csrRead = 16'h0000;
    readWord = 32'h0000_0000;
    s_d = s_q;
    s_d.pinSync1 = channelPin;
    s_d.pinSync2 = s_q.pinSync1;
    s_d.pinPrev = s_q.pinSync2;
    s_d.eqAPrev = eqA;
    s_d.eqBPrev = eqB;
    s_d.hresp = 1'b0;

    if (active) begin
      case (s_q.mode)
        MODE_DISABLED: begin
          s_d.widthArmed = 1'b0;
        end
        MODE_WIDTH: begin
          // Leading edge goes to B, trailing edge to A, so A minus B is the width.
          if (selEdge) begin
            s_d.dataB = busSel;
            s_d.widthArmed = 1'b1;
          end else if (otherEdge && s_q.widthArmed) begin
            s_d.dataA = busSel;
            s_d.widthArmed = 1'b0;
            setBits[IRQ_FLAG_BIT] = 1'b1;
          end
        end
        MODE_PERIOD: begin
          if (selEdge) begin
            s_d.dataB = s_q.dataA;
            s_d.dataA = busSel;
            setBits[IRQ_FLAG_BIT] = 1'b1;
          end
        end
        MODE_CAPTURE: begin
          if (selEdge) begin
            s_d.dataA = busSel;
            setBits[IRQ_FLAG_BIT] = 1'b1;
          end
        end
        MODE_CMP_SECOND, MODE_CMP_BOTH: begin
          if (matchA) begin
            s_d.outFf = 1'b1;
            setBits[IRQ_MATCH_A_BIT] = (s_q.mode == MODE_CMP_BOTH);
          end
          if (matchB) begin
            s_d.outFf = 1'b0;
            setBits[IRQ_FLAG_BIT] = 1'b1;
          end
        end
        default: begin
          // Codes 0110 and 0111 are reserved and do nothing.
          if (s_q.mode[3]) begin
            if (matchA) begin
              s_d.outFf = 1'b1;
            end
            if (matchB) begin
              s_d.outFf = 1'b0;
              setBits[IRQ_FLAG_BIT] = 1'b1;
            end
          end
        end
      endcase
    end

    csrRead[PIN_BIT] = s_q.pinSync2;
    csrRead[FREEZE_BIT] = s_q.freeze;
    csrRead[EDGE_BIT] = s_q.edgeFall;
    csrRead[BSL_LSB +: 2] = s_q.counter_bus_select;
    csrRead[MODE_LSB +: 4] = s_q.mode;
    case (s_q.addr)
      ADDR_DATA_A: readWord = {s_q.dataA, s_q.dataB};
      ADDR_DATA_B: readWord = {16'h0000, s_q.dataB};
      ADDR_STATUS_CONTROL: readWord = {16'h0000, csrRead};
      ADDR_IRQ_STATUS: readWord = {30'h0, s_q.irqStatus};
      ADDR_IRQ_ENABLE: readWord = {30'h0, s_q.irqEnable};
      default: readWord = 32'h0000_0000;
    endcase

    case (s_q.phase)
      DAC_BUS_IDLE: begin
        s_d.hreadyout = 1'b1;
      end
      DAC_BUS_WRITE: begin
        s_d.phase = DAC_BUS_IDLE;
        // Software data writes land after captures, so the write wins that cycle.
        case (s_q.addr)
          ADDR_DATA_A: s_d.dataA = hwdata[15:0];
          ADDR_DATA_B: s_d.dataB = hwdata[15:0];
          ADDR_STATUS_CONTROL: begin
            s_d.freeze = hwdata[FREEZE_BIT];
            s_d.edgeFall = hwdata[EDGE_BIT];
            s_d.counter_bus_select = hwdata[BSL_LSB +: 2];
            s_d.mode = hwdata[MODE_LSB +: 4];
            if (hwdata[FORCE_B_BIT] && outMode) begin
              s_d.outFf = 1'b0;
            end
          end
          ADDR_IRQ_ENABLE: s_d.irqEnable = hwdata[1:0];
          ADDR_IRQ_CLEAR: clrBits = hwdata[1:0];
          default: begin
          end
        endcase
      end
      DAC_BUS_READ: begin
        s_d.phase = DAC_BUS_IDLE;
        s_d.hrdata = readWord;
        s_d.hreadyout = 1'b1;
      end
      default: begin
        s_d.phase = DAC_BUS_IDLE;
        s_d.hreadyout = 1'b1;
      end
    endcase

    // Reads take one wait state so they see a write that just completed.
    if (accept) begin
      s_d.addr = haddr;
      s_d.phase = hwrite ? DAC_BUS_WRITE : DAC_BUS_READ;
      s_d.hreadyout = hwrite;
    end

    // A flag raised in the cycle it is cleared survives.
    s_d.irqStatus = (s_q.irqStatus & ~clrBits) | setBits;
    s_d.irq = |(s_d.irqStatus & s_d.irqEnable);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hreadyout;
  assign hresp = s_q.hresp;
  assign channelOut = s_q.outFf;
  assign irq = s_q.irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  logic noWrite;
  assign noWrite = (s_q.phase != DAC_BUS_WRITE);

  pin_level_a: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    |-> s_q.pinSync2 == $past(channelPin, 2))
    else $error("Pin readback does not follow the pin.");

  freeze_hold_a: assert property (
    (s_q.mode == MODE_CAPTURE && !active && selEdge && noWrite) |=> $stable(s_q.dataA))
    else $error("Frozen channel captured.");

  rising_capture_a: assert property (
    (!s_q.edgeFall && pinRise && s_q.mode == MODE_CAPTURE && active && noWrite)
    |=> s_q.irqStatus[IRQ_FLAG_BIT])
    else $error("Rising edge did not capture.");

  bus_select_a: assert property (
    (s_q.mode == MODE_CAPTURE && active && selEdge && noWrite)
    |=> s_q.dataA == $past(counterBuses[s_q.counter_bus_select]))
    else $error("Capture took the wrong counter bus.");

  width_end_a: assert property (
    (s_q.mode == MODE_WIDTH && active && otherEdge && s_q.widthArmed && noWrite)
    |=> s_q.irqStatus[IRQ_FLAG_BIT] && s_q.dataA == $past(busSel) && !s_q.widthArmed)
    else $error("Width measurement did not end on the trailing edge.");

  compare_flag_a: assert property (
    (s_q.mode == MODE_CMP_SECOND && active && matchB && noWrite)
    |=> s_q.irqStatus[IRQ_FLAG_BIT] && !channelOut)
    else $error("B match did not flag and clear the output.");

  pwm_mask_a: assert property (
    (s_q.mode == MODE_PWM_LOWEST && active && noWrite && !s_q.eqAPrev
     && busSel[15:9] == s_q.dataA[15:9] && busSel[15:9] != s_q.dataB[15:9])
    |=> channelOut)
    else $error("Coarse PWM compare missed an A match.");

  period_shift_a: assert property (
    (s_q.mode == MODE_PERIOD && active && selEdge && noWrite)
    |=> s_q.dataB == $past(s_q.dataA) && s_q.dataA == $past(busSel))
    else $error("Period capture did not shift A into B.");

  pair_read_a: assert property (
    (s_q.phase == DAC_BUS_READ && s_q.addr == ADDR_DATA_A)
    |=> hreadyout && hrdata == {$past(s_q.dataA), $past(s_q.dataB)})
    else $error("Pair read did not return A and B together.");

  force_b_a: assert property (
    (s_q.phase == DAC_BUS_WRITE && s_q.addr == ADDR_STATUS_CONTROL
     && hwdata[FORCE_B_BIT] && outMode)
    |=> !channelOut)
    else $error("Force B did not clear the output.");

  one_capture_a: assert property (
    selEdge |=> !selEdge)
    else $error("One pin edge gave two capture events.");

  period_cover: cover property (
    s_q.mode == MODE_PERIOD && selEdge ##[1:200] s_q.mode == MODE_PERIOD && selEdge);
  pwm_cover: cover property (s_q.mode[3] && matchA ##[1:500] matchB);
  irq_cover: cover property (!irq ##1 irq);
  pair_read_cover: cover property (s_q.phase == DAC_BUS_READ && s_q.addr == ADDR_DATA_A);
endmodule
`default_nettype wire

// File: dac_pkg.sv
`default_nettype none
package dac_pkg;
  // Register indices; the byte address of each register is four times its index.
  localparam logic [23:0] IDX_DATA_A = 24'h306058;
  localparam logic [23:0] IDX_STATUS_CONTROL = 24'h30605e;
  localparam logic [23:0] IDX_DATA_B = 24'h30605a;
  localparam logic [23:0] IDX_IRQ_STATUS = 24'h306060;
  localparam logic [23:0] IDX_IRQ_ENABLE = 24'h306061;
  localparam logic [23:0] IDX_IRQ_CLEAR = 24'h306062;
  localparam logic [31:0] ADDR_DATA_A = {6'h00, IDX_DATA_A, 2'h0};
  localparam logic [31:0] ADDR_STATUS_CONTROL = {6'h00, IDX_STATUS_CONTROL, 2'h0};
  localparam logic [31:0] ADDR_DATA_B = {6'h00, IDX_DATA_B, 2'h0};
  localparam logic [31:0] ADDR_IRQ_STATUS = {6'h00, IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] ADDR_IRQ_ENABLE = {6'h00, IDX_IRQ_ENABLE, 2'h0};
  localparam logic [31:0] ADDR_IRQ_CLEAR = {6'h00, IDX_IRQ_CLEAR, 2'h0};

  // Control bit positions; the pin level sits in the most significant bit.
  localparam int PIN_BIT = 15;
  localparam int FREEZE_BIT = 13;
  localparam int EDGE_BIT = 11;
  localparam int FORCE_B_BIT = 9;
  localparam int BSL_LSB = 5;
  localparam int MODE_LSB = 0;

  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_MATCH_A_BIT = 1;

  localparam logic [3:0] MODE_DISABLED = 4'h0;
  localparam logic [3:0] MODE_WIDTH = 4'h1;
  localparam logic [3:0] MODE_PERIOD = 4'h2;
  localparam logic [3:0] MODE_CAPTURE = 4'h3;
  localparam logic [3:0] MODE_CMP_SECOND = 4'h4;
  localparam logic [3:0] MODE_CMP_BOTH = 4'h5;
  localparam logic [3:0] MODE_PWM_LOWEST = 4'hf;

  typedef enum logic [1:0] {DAC_BUS_IDLE, DAC_BUS_WRITE, DAC_BUS_READ} dac_bus_t;

  typedef struct packed {
    logic pinSync1;
    logic pinSync2;
    logic pinPrev;
    logic freeze;
    logic edgeFall;
    logic [1:0] counter_bus_select;
    logic [3:0] mode;
    logic [15:0] dataA;
    logic [15:0] dataB;
    logic widthArmed;
    logic eqAPrev;
    logic eqBPrev;
    logic outFf;
    logic [1:0] irqStatus;
    logic [1:0] irqEnable;
    logic irq;
    dac_bus_t phase;
    logic [31:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } dac_state_t;

  localparam dac_state_t STATE_RESET = '{hreadyout: 1'b1, phase: DAC_BUS_IDLE, default: '0};

  // Number of low counter-bus bits left out of a PWM compare.
  function automatic logic [3:0] dac_ignore_bits(input logic [3:0] mode);
    case (mode)
      4'h9: dac_ignore_bits = 4'h1;
      4'ha: dac_ignore_bits = 4'h2;
      4'hb: dac_ignore_bits = 4'h3;
      4'hc: dac_ignore_bits = 4'h4;
      4'hd: dac_ignore_bits = 4'h5;
      4'he: dac_ignore_bits = 4'h7;
      4'hf: dac_ignore_bits = 4'h9;
      default: dac_ignore_bits = 4'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: dac_wave_model.sv
`timescale 1ns/10ps
`default_nettype none
module dac_wave_model (
  input wire logic clock,
  input wire logic run,
  input wire logic level,
  input wire logic [7:0] halfLen,
  output logic channelPin,
  output logic [3:0][15:0] counterBuses
);
  logic [15:0] tick = 16'h0000;
  logic [7:0] phase = 8'h00;
  logic wave = 1'b0;
  // Each bus counts at its own rate, so a wrong bus select shows in any difference.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      counterBuses[i] = tick * 16'(i + 1);
    end
    channelPin = run ? wave : level;
  end
  always_ff @(posedge clock) begin
    tick <= tick + 16'h0001;
    phase <= (phase >= halfLen - 8'h01) ? 8'h00 : phase + 8'h01;
    if (phase >= halfLen - 8'h01) begin
      wave <= ~wave;
    end
  end
endmodule
`default_nettype wire

// File: dual_action_capture_compare_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dual_action_capture_compare_bench;
  import dac_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, channelPin, channelOut, irq;
  logic [3:0][15:0] counterBuses;
  logic debugHalt = 1'b0;
  logic run = 1'b0;
  logic level = 1'b0;
  logic [7:0] halfLen = 8'h08;
  logic [31:0] seed = 32'hf3c6;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [15:0] t0;
  logic [3:0] md;
  logic [1:0] bs;
  always #10 clock = ~clock;
  dac_channel u_dut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .channelPin(channelPin),
    .counterBuses(counterBuses), .debugHalt(debugHalt), .channelOut(channelOut), .irq(irq));
  dac_wave_model u_wave (.clock(clock), .run(run), .level(level), .halfLen(halfLen),
    .channelPin(channelPin), .counterBuses(counterBuses));

  function automatic logic [31:0] xorshift(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // Ticks between the two stored counts: a whole period, or half a period in width mode.
  function automatic logic [15:0] gap(input logic [7:0] h, input logic [1:0] b,
                                      input logic [3:0] m);
    return 16'(h * (b + 1) * (m == MODE_PERIOD ? 2 : 1));
  endfunction

  // Called just after a rising edge; returns at the edge that ends the data phase.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_level(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check_level("irq after reset", 1'b0, irq);
    check_level("ready after reset", 1'b1, hreadyout);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
    bus(1'b1, ADDR_STATUS_CONTROL, 32'h0202);
    bus(1'b0, ADDR_STATUS_CONTROL, 32'h0);
    check_word("control readback", 32'h0002, rd);
    level <= 1'b1;
    repeat (4) @(posedge clock);
    bus(1'b0, ADDR_STATUS_CONTROL, 32'h0);
    check_word("pin readback", 32'h8002, rd);
    level <= 1'b0;
    bus(1'b1, ADDR_STATUS_CONTROL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      bs = seed[5:4];
      md = seed[6] ? MODE_WIDTH : MODE_PERIOD;
      halfLen <= 8'h06 + 8'(seed[3:0]);
      run <= 1'b1;
      bus(1'b1, ADDR_STATUS_CONTROL,
          (32'(seed[7]) << EDGE_BIT) | (32'(bs) << BSL_LSB) | 32'(md));
      repeat (200) @(posedge clock);
      // Read just after the closing edge, before the next opening edge can move B.
      while (u_wave.wave === seed[7]) @(posedge clock);
      while (u_wave.wave !== seed[7]) @(posedge clock);
      repeat (3) @(posedge clock);
      bus(1'b0, ADDR_DATA_A, 32'h0);
      check_word("pair gap", 32'(gap(halfLen, bs, md)), 32'(16'(rd[31:16] - rd[15:0])));
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      check_level("capture flag", 1'b1, rd[IRQ_FLAG_BIT]);
      check_level("irq raised", 1'b1, irq);
      bus(1'b1, ADDR_STATUS_CONTROL, 32'h0);
      bus(1'b1, ADDR_IRQ_CLEAR, 32'h3);
      @(posedge clock);
      check_level("irq cleared", 1'b0, irq);
    end
    debugHalt <= 1'b1;
    bus(1'b1, ADDR_STATUS_CONTROL, 32'h2003);
    bus(1'b0, ADDR_DATA_A, 32'h0);
    t0 = rd[31:16];
    repeat (100) @(posedge clock);
    bus(1'b0, ADDR_DATA_A, 32'h0);
    check_word("frozen data", 32'(t0), 32'(rd[31:16]));
    bus(1'b1, ADDR_STATUS_CONTROL, 32'h0003);
    repeat (100) @(posedge clock);
    bus(1'b0, ADDR_DATA_A, 32'h0);
    check_level("running capture", 1'b1, rd[31:16] != t0);
    debugHalt <= 1'b0;
    run <= 1'b0;
    for (int m = 4; m < 6; m++) begin
      bus(1'b1, ADDR_STATUS_CONTROL, 32'h0);
      bus(1'b1, ADDR_IRQ_CLEAR, 32'h3);
      t0 = u_wave.tick;
      bus(1'b1, ADDR_DATA_A, 32'(t0 + 16'd40));
      bus(1'b1, ADDR_DATA_B, 32'(t0 + 16'd80));
      bus(1'b1, ADDR_STATUS_CONTROL, 32'(m));
      repeat (45) @(posedge clock);
      check_level("compare output", 1'b1, channelOut);
      bus(1'b1, ADDR_STATUS_CONTROL, 32'(m) | 32'h0200);
      @(posedge clock);
      check_level("forced output", 1'b0, channelOut);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      check_word("status after force", (m == 5) ? 32'h2 : 32'h0, rd);
      repeat (40) @(posedge clock);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      check_word("status after b", (m == 5) ? 32'h3 : 32'h1, rd);
    end
    bus(1'b1, ADDR_STATUS_CONTROL, 32'h0);
    t0 = (u_wave.tick + 16'h0400) & 16'hfe00;
    bus(1'b1, ADDR_DATA_A, 32'(t0 + 16'h0123));
    bus(1'b1, ADDR_DATA_B, 32'(t0 + 16'h0400));
    bus(1'b1, ADDR_STATUS_CONTROL, {28'h0, MODE_PWM_LOWEST});
    while (u_wave.tick != t0 + 16'd40) @(posedge clock);
    check_level("coarse pwm set", 1'b1, channelOut);
    while (u_wave.tick != t0 + 16'h0428) @(posedge clock);
    check_level("coarse pwm clear", 1'b0, channelOut);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check_level("output after reset", 1'b0, channelOut);
    bus(1'b0, ADDR_STATUS_CONTROL, 32'h0);
    check_word("control after reset", 32'h0, rd);
    check_level("okay response", 1'b0, hresp);
    final_report();
  end
endmodule
`default_nettype wire
